/* logic/conv_ctrl.sv */
// Control logic of a 10-bit successive-approximation converter with register port.
`timescale 1ns/1ps
module conv_ctrl #(
    parameter int CHANNELS = 8
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    output logic IRQ_O,
    input wire logic RC_OSC_I,
    input wire logic COMP_I,
    input wire logic [CHANNELS-1:0] PIN_LEVEL_I,
    input wire logic [CHANNELS-1:0] PIN_DIRECTION_I,
    output logic [2:0] CHANNEL_O,
    output logic HOLD_CONNECT_O,
    output logic CONVERT_DRIVEN_O,
    output logic [9:0] TRIAL_CODE_O
);
    // Refuse a channel count that the port configuration table cannot serve.
    if (CHANNELS != 8) begin : g_chan_check
        $error("CHANNELS must be 8 to match the port configuration table");
    end

    conv_ctrl_pkg::ctrl_first_t ctrl_first_r;
    conv_ctrl_pkg::ctrl_second_t ctrl_second_r;
    conv_ctrl_pkg::conv_state_t state_r;
    conv_ctrl_pkg::conv_state_t state_nxt;
    logic [9:0] result_r;
    logic [9:0] sar_r;
    logic [3:0] period_cnt_r;
    logic [3:0] period_nxt;
    logic done_flag_r;
    logic [1:0] irq_en_r;
    logic [CHANNELS-1:0] pin_s1_r;
    logic [CHANNELS-1:0] pin_s2_r;
    logic [CHANNELS-1:0] pin_s3_r;
    logic [CHANNELS-1:0] pin_stable_r;
    logic comp_s1_r;
    logic comp_s2_r;
    logic comp_s3_r;
    logic comp_stable_r;
    logic tick;
    logic run;
    logic wr_first;
    logic go_clear_wr;
    logic conv_end;
    logic abort;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic [7:0] rd_mux;

    // Port configuration code to mask of pins that are not digital.
    function automatic logic [7:0] analog_mask(input logic [3:0] pcfg);
        case (pcfg)
            4'h0, 4'h1, 4'h8: analog_mask = 8'hFF;
            4'h2, 4'h3, 4'hC: analog_mask = 8'h1F;
            4'h4, 4'h5: analog_mask = 8'h0B;
            4'h6, 4'h7: analog_mask = 8'h00;
            4'h9, 4'hA, 4'hB: analog_mask = 8'h3F;
            4'hD: analog_mask = 8'h0F;
            4'hE: analog_mask = 8'h01;
            4'hF: analog_mask = 8'h0D;
            default: analog_mask = 8'h00;
        endcase
    endfunction : analog_mask

    assign wr_first = WR_I && (ADDR_I == conv_ctrl_pkg::OFS_CTRL_FIRST);
    assign go_clear_wr = wr_first && !WDATA_I[conv_ctrl_pkg::CF_GO];
    // A cut conversion restarts the divider, so the holdoff spans two full periods with a divided clock but may be one period short with the RC clock.
    assign run = (state_r != conv_ctrl_pkg::ST_IDLE) && !abort;
    assign conv_end = (state_r == conv_ctrl_pkg::ST_CONVERT) && tick
        && (period_nxt == conv_ctrl_pkg::CONV_PERIODS);
    assign abort = (state_r == conv_ctrl_pkg::ST_CONVERT) && !conv_end
        && (go_clear_wr || !ctrl_first_r.on);
    assign period_nxt = period_cnt_r + 4'h1;

    bit_period_gen #(
        .DIV_BITS(7)
    ) u_bit_period (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .run_i(run),
        .sel_i({ctrl_second_r.clk_hi, ctrl_first_r.clk_lo}),
        .rc_osc_i(RC_OSC_I),
        .tick_o(tick)
    );

    // Three-stage synchronisers for the pin levels and the comparator.
    always_ff @(posedge CLK_SYS_I) begin
        pin_s1_r <= PIN_LEVEL_I;
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
        comp_s1_r <= COMP_I;
        comp_s2_r <= comp_s1_r;
        comp_s3_r <= comp_s2_r;
    end

    // Filtered levels follow once the last two stages agree.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            pin_stable_r <= '0;
            comp_stable_r <= 1'b0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (pin_s2_r[i] == pin_s3_r[i]) begin
                    pin_stable_r[i] <= pin_s3_r[i];
                end
            end
            if (comp_s2_r == comp_s3_r) begin
                comp_stable_r <= comp_s3_r;
            end
        end
    end

    // Sequencer next state.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            conv_ctrl_pkg::ST_IDLE: begin
                if (ctrl_first_r.go && ctrl_first_r.on) begin
                    state_nxt = conv_ctrl_pkg::ST_CONVERT;
                end
            end
            conv_ctrl_pkg::ST_CONVERT: begin
                if (conv_end || abort || !ctrl_first_r.on) begin
                    state_nxt = conv_ctrl_pkg::ST_HOLDOFF;
                end
            end
            conv_ctrl_pkg::ST_HOLDOFF: begin
                if (tick && period_nxt == conv_ctrl_pkg::HOLDOFF_PERIODS) begin
                    state_nxt = conv_ctrl_pkg::ST_IDLE;
                end
            end
            default: state_nxt = conv_ctrl_pkg::ST_IDLE;
        endcase
    end

    // Sequencer state register.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            state_r <= conv_ctrl_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Bit-period counter restarts on every state change.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_nxt != state_r) begin
            period_cnt_r <= 4'h0;
        end else if (tick) begin
            period_cnt_r <= period_nxt;
        end
    end

    // Successive approximation: periods two to eleven each settle one bit.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || state_r != conv_ctrl_pkg::ST_CONVERT) begin
            sar_r <= conv_ctrl_pkg::SAR_START;
        end else if (tick && period_nxt >= conv_ctrl_pkg::FIRST_RESOLVE
                && period_nxt < conv_ctrl_pkg::CONV_PERIODS) begin
            for (int b = 0; b < conv_ctrl_pkg::RESULT_BITS; b++) begin
                if (4'(11 - b) == period_nxt) begin
                    sar_r[b] <= comp_stable_r;
                    if (b > 0) begin
                        sar_r[b-1] <= 1'b1;
                    end
                end
            end
        end
    end

    // Result has no reset; loaded only at normal completion.
    always_ff @(posedge CLK_SYS_I) begin
        if (conv_end) begin
            result_r <= sar_r;
        end
    end

    // First control register; start bit cleared by hardware on completion.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ctrl_first_r <= conv_ctrl_pkg::CTRL_FIRST_RST;
        end else begin
            if (wr_first) begin
                ctrl_first_r <= WDATA_I;
                ctrl_first_r.rsv <= 1'b0;
            end
            if (conv_end || (state_r == conv_ctrl_pkg::ST_CONVERT && !ctrl_first_r.on)) begin
                ctrl_first_r.go <= 1'b0;
            end
        end
    end

    // Second control register holds top select bit.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ctrl_second_r <= conv_ctrl_pkg::CTRL_SECOND_RST;
        end else if (WR_I && ADDR_I == conv_ctrl_pkg::OFS_CTRL_SECOND) begin
            ctrl_second_r <= WDATA_I & 8'hCF;
        end
    end

    // Done flag: completion wins over clear.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            done_flag_r <= 1'b0;
        end else if (conv_end) begin
            done_flag_r <= 1'b1;
        end else if (WR_I && ADDR_I == conv_ctrl_pkg::OFS_IRQ_CLEAR
                && WDATA_I[conv_ctrl_pkg::IRQ_DONE]) begin
            done_flag_r <= 1'b0;
        end
    end

    // Interrupt enable register.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            irq_en_r <= conv_ctrl_pkg::IRQ_EN_RST;
        end else if (WR_I && ADDR_I == conv_ctrl_pkg::OFS_IRQ_ENABLE) begin
            irq_en_r <= WDATA_I[1:0];
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= done_flag_r && irq_en_r[conv_ctrl_pkg::IRQ_DONE]
                && irq_en_r[conv_ctrl_pkg::IRQ_GLOBAL];
        end
    end

    assign res_high = ctrl_second_r.justify ? {6'h00, result_r[9:8]} : result_r[9:2];
    assign res_low = ctrl_second_r.justify ? result_r[7:0] : {result_r[1:0], 6'h00};

    // Read data selection.
    always_comb begin
        case (ADDR_I)
            conv_ctrl_pkg::OFS_CTRL_FIRST: rd_mux = ctrl_first_r;
            conv_ctrl_pkg::OFS_CTRL_SECOND: rd_mux = ctrl_second_r;
            conv_ctrl_pkg::OFS_RESULT_HIGH: rd_mux = res_high;
            conv_ctrl_pkg::OFS_RESULT_LOW: rd_mux = res_low;
            conv_ctrl_pkg::OFS_IRQ_STATUS: rd_mux = {7'h00, done_flag_r};
            conv_ctrl_pkg::OFS_IRQ_ENABLE: rd_mux = {6'h00, irq_en_r};
            conv_ctrl_pkg::OFS_PORT_DATA: rd_mux = pin_stable_r & ~analog_mask(ctrl_second_r.pcfg);
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || !RD_I) begin
            RDATA_O <= 8'h00;
        end else begin
            RDATA_O <= rd_mux;
        end
    end

    // Analog front-end controls.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            CHANNEL_O <= 3'h0;
            HOLD_CONNECT_O <= 1'b0;
            CONVERT_DRIVEN_O <= 1'b0;
            TRIAL_CODE_O <= 10'h000;
        end else begin
            CHANNEL_O <= ctrl_first_r.chan;
            HOLD_CONNECT_O <= ctrl_first_r.on && state_nxt == conv_ctrl_pkg::ST_IDLE;
            CONVERT_DRIVEN_O <= !PIN_DIRECTION_I[ctrl_first_r.chan];
            TRIAL_CODE_O <= sar_r;
        end
    end
endmodule : conv_ctrl

/* logic/conv_ctrl_pkg.sv */
// Shared constants and types for the converter control block.
package conv_ctrl_pkg;
    // Register indices on the plain register port.
    localparam logic [2:0] OFS_CTRL_FIRST = 3'h0;
    localparam logic [2:0] OFS_CTRL_SECOND = 3'h1;
    localparam logic [2:0] OFS_RESULT_HIGH = 3'h2;
    localparam logic [2:0] OFS_RESULT_LOW = 3'h3;
    localparam logic [2:0] OFS_IRQ_STATUS = 3'h4;
    localparam logic [2:0] OFS_IRQ_CLEAR = 3'h5;
    localparam logic [2:0] OFS_IRQ_ENABLE = 3'h6;
    localparam logic [2:0] OFS_PORT_DATA = 3'h7;

    // Field positions in the first control register.
    localparam int CF_CLK_LO = 6;
    localparam int CF_CHAN_LO = 3;
    localparam int CF_GO = 2;
    localparam int CF_ON = 0;
    // Field positions in the second control register.
    localparam int CS_JUSTIFY = 7;
    localparam int CS_CLK_HI = 6;
    localparam int CS_PCFG_LO = 0;
    // Interrupt register bits.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_GLOBAL = 1;

    // Reset values.
    localparam logic [7:0] CTRL_FIRST_RST = 8'h00;
    localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
    localparam logic [1:0] IRQ_EN_RST = 2'h0;

    // Conversion timing in bit periods.
    localparam logic [3:0] CONV_PERIODS = 4'hC;
    localparam logic [3:0] FIRST_RESOLVE = 4'h2;
    localparam logic [3:0] HOLDOFF_PERIODS = 4'h2;
    localparam int RESULT_BITS = 10;
    localparam logic [9:0] SAR_START = 10'h200;

    // Low select bits that pick the RC oscillator; the RC codes have bits 1:0 set.
    localparam logic [1:0] SEL_RC_LO = 2'h3;

    // Conversion sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONVERT = 3'b010,
        ST_HOLDOFF = 3'b100
    } conv_state_t;

    // First control register as a carrier of its fields.
    typedef struct packed {
        logic [1:0] clk_lo;
        logic [2:0] chan;
        logic go;
        logic rsv;
        logic on;
    } ctrl_first_t;

    // Second control register as a carrier of its fields.
    typedef struct packed {
        logic justify;
        logic clk_hi;
        logic [1:0] rsv;
        logic [3:0] pcfg;
    } ctrl_second_t;
endpackage : conv_ctrl_pkg

/* logic/bit_period_gen.sv */
// Bit-period tick generator: system clock divider or synchronised RC oscillator.
`timescale 1ns/1ps
module bit_period_gen #(
    parameter int DIV_BITS = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    input wire logic rc_osc_i,
    output logic tick_o
);
    // Refuse a counter too narrow for the slowest ratio.
    if (DIV_BITS < 7) begin : g_div_check
        $error("DIV_BITS too small for a divide by 64");
    end

    logic [DIV_BITS-1:0] div_cnt_r;
    logic [DIV_BITS-1:0] div_last;
    logic rc_s1_r;
    logic rc_s2_r;
    logic rc_s3_r;
    logic rc_stable_r;
    logic rc_rise;
    logic use_rc;

    // Codes 000,100,001,101,010,110 give 2,4,8,16,32,64 oscillator periods; x11 picks the RC oscillator.
    assign use_rc = (sel_i[1:0] == conv_ctrl_pkg::SEL_RC_LO);
    assign div_last = DIV_BITS'((2 << (sel_i[2] + 2 * sel_i[1:0]) >> 1) * 2 - 1);

    // Three-stage synchroniser for the free-running RC oscillator.
    always_ff @(posedge clk_i) begin
        rc_s1_r <= rc_osc_i;
        rc_s2_r <= rc_s1_r;
        rc_s3_r <= rc_s2_r;
    end

    // Accept RC level once stages agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_stable_r <= 1'b0;
        end else if (rc_s2_r == rc_s3_r) begin
            rc_stable_r <= rc_s3_r;
        end
    end

    assign rc_rise = (rc_s2_r == rc_s3_r) && rc_s3_r && !rc_stable_r;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            div_cnt_r <= '0;
            tick_o <= 1'b0;
        end else if (use_rc) begin
            div_cnt_r <= '0;
            tick_o <= rc_rise;
        end else if (div_cnt_r == div_last) begin
            div_cnt_r <= '0;
            tick_o <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule : bit_period_gen

/* test/conv_ctrl_chk.sv */
// Port-level assertion checker for the converter control block.
`timescale 1ns/1ps
module conv_ctrl_chk #(
    parameter int CHANNELS = 8
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic IRQ_O,
    input wire logic RC_OSC_I,
    input wire logic COMP_I,
    input wire logic [CHANNELS-1:0] PIN_LEVEL_I,
    input wire logic [CHANNELS-1:0] PIN_DIRECTION_I,
    input wire logic [2:0] CHANNEL_O,
    input wire logic HOLD_CONNECT_O,
    input wire logic CONVERT_DRIVEN_O,
    input wire logic [9:0] TRIAL_CODE_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    AST_START_OPENS: assert property (
        WR_I && ADDR_I == 3'h0 && WDATA_I[2] && WDATA_I[0] && HOLD_CONNECT_O
        |-> ##[1:3] !HOLD_CONNECT_O) else $error("Hold switch stayed closed.");
    AST_HOLDOFF: assert property (
        $rose(IRQ_O) && !HOLD_CONNECT_O |=> !HOLD_CONNECT_O [*2])
        else $error("Acquisition restarted too early.");
    AST_CHANNEL: assert property (
        WR_I && ADDR_I == 3'h0 |-> ##2 CHANNEL_O == $past(WDATA_I[5:3], 2))
        else $error("Channel output missed a write.");
    AST_DRIVEN: assert property (
        $stable(PIN_DIRECTION_I) && $stable(CHANNEL_O) ##1 $stable(PIN_DIRECTION_I)
        && $stable(CHANNEL_O) |-> CONVERT_DRIVEN_O == !PIN_DIRECTION_I[CHANNEL_O])
        else $error("Driven-level flag wrong.");
    AST_IRQ_CLEAR: assert property (
        WR_I && ADDR_I == 3'h5 && WDATA_I[0] && HOLD_CONNECT_O |-> ##[1:2] !IRQ_O)
        else $error("Request stayed after clear.");
    AST_IRQ_MASK: assert property (
        WR_I && ADDR_I == 3'h6 && !(&WDATA_I[1:0]) |-> ##2 !IRQ_O)
        else $error("Masked request still high.");
    AST_ABORT: assert property (
        WR_I && ADDR_I == 3'h0 && !WDATA_I[2] && !HOLD_CONNECT_O && !IRQ_O
        |=> !IRQ_O [*3]) else $error("Abort raised a request.");
    AST_RSV_ZERO: assert property (
        RD_I && ADDR_I == 3'h1 |=> RDATA_O[5:4] == 2'h0)
        else $error("Reserved bits read nonzero.");

    // Main scenarios reached.
    COV_START: cover property ($fell(HOLD_CONNECT_O));
    COV_IRQ: cover property ($rose(IRQ_O));
    COV_REACQ: cover property ($rose(HOLD_CONNECT_O));
endmodule : conv_ctrl_chk

bind conv_ctrl conv_ctrl_chk #(.CHANNELS(CHANNELS)) u_chk (.CLK_SYS_I, .RST_I, .ADDR_I,
    .WDATA_I, .WR_I, .RD_I, .RDATA_O, .IRQ_O, .RC_OSC_I, .COMP_I, .PIN_LEVEL_I,
    .PIN_DIRECTION_I, .CHANNEL_O, .HOLD_CONNECT_O, .CONVERT_DRIVEN_O, .TRIAL_CODE_O);

/* test/conv_ctrl_tb.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module conv_ctrl_tb;
    logic CLK_SYS_I = 1'b0;
    logic RST_I = 1'b1;
    logic [2:0] ADDR_I = 3'h0;
    logic [7:0] WDATA_I = 8'h00;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic RC_OSC_I = 1'b0;
    logic COMP_I = 1'b0;
    logic [7:0] PIN_LEVEL_I = 8'hA5;
    logic [7:0] PIN_DIRECTION_I = 8'hFF;
    logic [7:0] RDATA_O;
    logic IRQ_O;
    logic [2:0] CHANNEL_O;
    logic HOLD_CONNECT_O;
    logic CONVERT_DRIVEN_O;
    logic [9:0] TRIAL_CODE_O;
    logic [9:0] vin = 10'h000;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int rc_cnt = 0;
    // Pins that each port configuration code leaves analog, code 15 first.
    logic [15:0][7:0] analog_pins = {8'h0D, 8'h01, 8'h0F, 8'h1F, 8'h3F, 8'h3F, 8'h3F, 8'hFF,
        8'h00, 8'h00, 8'h0B, 8'h0B, 8'h1F, 8'h1F, 8'hFF, 8'hFF};

    conv_ctrl dut (.CLK_SYS_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .IRQ_O,
        .RC_OSC_I, .COMP_I, .PIN_LEVEL_I, .PIN_DIRECTION_I, .CHANNEL_O, .HOLD_CONNECT_O,
        .CONVERT_DRIVEN_O, .TRIAL_CODE_O);

    // The clock runs at 25 MHz.
    initial begin
        forever #20 CLK_SYS_I = ~CLK_SYS_I;
    end

    // Comparator model, a six-clock RC oscillator and the hang limit.
    // Sleep lies outside the block; the RC source runs free.
    always @(posedge CLK_SYS_I) begin
        COMP_I <= (vin >= TRIAL_CODE_O);
        rc_cnt <= (rc_cnt == 5) ? 0 : rc_cnt + 1;
        RC_OSC_I <= (rc_cnt < 3);
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input string w, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", w, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK_SYS_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge CLK_SYS_I);
        WR_I <= 1'b0;
    endtask : wr

    // A read's data stand only in the cycle after the strobe.
    task automatic rdc(input string w, input logic [2:0] a, input logic [7:0] e);
        @(posedge CLK_SYS_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLK_SYS_I);
        RD_I <= 1'b0;
        @(negedge CLK_SYS_I);
        chk(w, RDATA_O, e);
    endtask : rdc

    task automatic conclude();
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    initial begin
        logic [2:0] sel;
        logic rcm;
        int p;
        int n;
        int h;
        repeat (4) @(posedge CLK_SYS_I);
        RST_I <= 1'b0;
        rdc("result_high", 3'h2, 8'hXX);
        rdc("ctrl_first", 3'h0, 8'h00);
        rdc("irq_status", 3'h4, 8'h00);
        wr(3'h1, 8'hFF);
        rdc("ctrl_second", 3'h1, 8'hCF);
        wr(3'h0, 8'hC2);
        rdc("ctrl_first", 3'h0, 8'hC0);
        rdc("irq_clear", 3'h5, 8'h00);
        // Port reads against pin configuration.
        wr(3'h1, 8'h00);
        rdc("port_all_analog", 3'h7, 8'h00);
        wr(3'h1, 8'h06);
        rdc("port_digital", 3'h7, 8'hA5);
        wr(3'h1, 8'h02);
        rdc("port_mixed", 3'h7, 8'hA0);
        for (int c = 0; c < 16; c++) begin
            wr(3'h1, 8'(c));
            rdc("port_cfg", 3'h7, 8'hA5 & ~analog_pins[c]);
        end
        // Output pin selected, then an input pin.
        @(posedge CLK_SYS_I);
        PIN_DIRECTION_I <= 8'hFE;
        wr(3'h0, 8'h01);
        repeat (4) @(posedge CLK_SYS_I);
        chk("driven", CONVERT_DRIVEN_O, 1'b1);
        wr(3'h0, 8'h09);
        repeat (4) @(posedge CLK_SYS_I);
        chk("driven", CONVERT_DRIVEN_O, 1'b0);
        wr(3'h6, 8'h03);
        // Every select code, ending on a slow divided one.
        for (int i = 0; i < 8; i++) begin
            sel = 3'(i + 7);
            rcm = (sel[1:0] == 2'h3);
            p = rcm ? 6 : (1 << (1 + sel[2] + 2 * sel[1:0]));
            vin <= 10'h2A5 + 10'(i * 71);
            wr(3'h5, 8'h01);
            wr(3'h1, {1'b1, sel[2], 6'h00});
            wr(3'h0, {sel[1:0], 6'h11});
            repeat (20) @(posedge CLK_SYS_I);
            wr(3'h0, {sel[1:0], 6'h15});
            n = 0;
            h = 0;
            while (IRQ_O !== 1'b1 && n < 2000) begin
                @(negedge CLK_SYS_I);
                n++;
            end
            while (HOLD_CONNECT_O !== 1'b1 && h < 1000) begin
                @(negedge CLK_SYS_I);
                h++;
            end
            chk("conv_len", n >= (rcm ? 11 : 12) * p && n <= 12 * p + (rcm ? 9 : 5), 1);
            chk("holdoff", h >= (rcm ? p : 2 * p - 2) && h <= 2 * p + 9, 1);
            rdc("go_cleared", 3'h0, {sel[1:0], 6'h11});
            rdc("done_flag", 3'h4, 8'h01);
            // Results only where the comparator settles.
            if (!rcm && p >= 8) begin
                rdc("right_high", 3'h2, {6'h00, vin[9:8]});
                rdc("right_low", 3'h3, vin[7:0]);
            end
        end
        // Masking and clearing of the request.
        chk("irq", IRQ_O, 1'b1);
        wr(3'h6, 8'h01);
        repeat (2) @(negedge CLK_SYS_I);
        chk("irq_masked", IRQ_O, 1'b0);
        wr(3'h6, 8'h03);
        repeat (2) @(negedge CLK_SYS_I);
        chk("irq", IRQ_O, 1'b1);
        wr(3'h5, 8'h01);
        rdc("flag_cleared", 3'h4, 8'h00);
        wr(3'h1, 8'h40);
        rdc("left_high", 3'h2, vin[9:2]);
        rdc("left_low", 3'h3, {vin[1:0], 6'h00});
        // Abort a slow conversion early, before its first bit settles.
        vin <= ~vin;
        wr(3'h0, 8'h95);
        repeat (100) @(posedge CLK_SYS_I);
        wr(3'h0, 8'h91);
        h = 0;
        while (HOLD_CONNECT_O !== 1'b1 && h < 1000) begin
            @(negedge CLK_SYS_I);
            h++;
        end
        chk("abort_holdoff", h >= 126 && h <= 137, 1);
        rdc("abort_flag", 3'h4, 8'h00);
        rdc("abort_result", 3'h2, ~vin[9:2]);
        // A second reset leaves the result alone.
        @(posedge CLK_SYS_I);
        RST_I <= 1'b1;
        repeat (2) @(posedge CLK_SYS_I);
        RST_I <= 1'b0;
        rdc("kept_high", 3'h2, ~vin[9:2]);
        rdc("ctrl_first", 3'h0, 8'h00);
        conclude();
    end
endmodule : conv_ctrl_tb
